// file: pkg/abm_pkg.sv
// abm_pkg: offsets, field positions, reset values and widths for the aux pin
// and manual bias register bank; shared by all abm design files
`default_nettype none

package abm_pkg;

  // pages as selected by the serial front end
  localparam logic [7:0] PAGE_CFG = 8'h02;
  localparam logic [7:0] PAGE_VLUT = 8'h06;

  // register offsets
  localparam logic [7:0] OFF_OUT_STATE = 8'h78;
  localparam logic [7:0] OFF_POWERUP_CTL = 8'hC0;
  localparam logic [7:0] OFF_AUX_CODE = 8'hC4;
  localparam logic [7:0] OFF_VTABLE_SEL = 8'hC7;
  localparam logic [7:0] OFF_NOMEM_FIRST = 8'hC8;
  localparam logic [7:0] OFF_NOMEM_LAST = 8'hF7;
  localparam logic [7:0] OFF_MAN_HIGH = 8'hF8;
  localparam logic [7:0] OFF_MAN_LOW = 8'hF9;
  localparam logic [7:0] OFF_MAN_STROBE = 8'hFA;
  localparam logic [7:0] OFF_LIVE_HIGH = 8'hFB;
  localparam logic [7:0] OFF_LIVE_LOW = 8'hFC;
  localparam logic [7:0] OFF_VLUT_FIRST = 8'h80;
  localparam logic [7:0] OFF_VLUT_LAST = 8'h9F;

  // field positions
  localparam int POS_PASS_INVERT = 5;
  localparam int POS_PIN0_SOURCE = 4;
  localparam int POS_TABLE_SPLIT = 1;
  localparam int POS_TABLE_HALF = 0;
  localparam int POS_STROBE = 0;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_OUT_STATE = 4'h0;
  localparam logic [13:0] RST_BIAS_CODE = 14'h0000;

  // widths and limits
  localparam int BIAS_W = 14;
  localparam int VLUT_DEPTH = 32;
  localparam int VLUT_IDX_W = 5;
  localparam logic [7:0] MAX_LIMIT_MANUAL = 8'hFF;
  localparam logic [5:0] CLAMP_LOW_FILL = 6'h3F;

endpackage : abm_pkg

`default_nettype wire

// file: tb/abm_host.sv
// abm_host: host side of the register bank, one byte access per task call
// assumes the bank samples requests on the rising edge of sys_clk_i
`default_nettype none

module abm_host
(
  input wire logic sys_clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] page_o,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    page_o = 8'h00;
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // each call is its own transaction: staging and strobe never merge
  task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
    @(negedge sys_clk_i);
    page_o = pg;
    addr_o = ad;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge sys_clk_i);
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] pg, input logic [7:0] ad, output logic [7:0] d);
    @(negedge sys_clk_i);
    page_o = pg;
    addr_o = ad;
    rd_o = 1'b1;
    @(negedge sys_clk_i);
    rd_o = 1'b0;
    d = rdata_i;
  endtask : rd
endmodule : abm_host

`default_nettype wire

// file: tb/abm_regs_props.sv
// abm_regs_chk: port-level assertions for the aux pin and manual bias bank
// assumes it is bound onto abm_regs and sees only that module's ports
`default_nettype none

module abm_regs_chk
  import abm_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] bus_page_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic [7:0] bus_rdata_o,
  input wire logic level_two_password_i,
  input wire logic bias_auto_enable_i,
  input wire logic [7:0] aux_analog_out_one_o,
  input wire logic [BIAS_W-1:0] laser_bias_current_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  wire cfg_rd = bus_rd_i && (bus_page_i == PAGE_CFG);
  wire cfg_ok = (bus_page_i == PAGE_CFG) && level_two_password_i;
  wire aux_wr = bus_wr_i && cfg_ok && (bus_addr_i == OFF_AUX_CODE);
  wire strb_wr = bus_wr_i && cfg_ok && (bus_addr_i == OFF_MAN_STROBE) && bus_wdata_i[POS_STROBE];
  wire rsv = bus_addr_i inside {[8'hC1:8'hC3], 8'hC5, 8'hC6, [OFF_NOMEM_FIRST:OFF_NOMEM_LAST]};
  // four quiet cycles so a late automatic update is not mistaken for a load
  sequence s_manual_steady;
    !bias_auto_enable_i [*4];
  endsequence
  sequence s_bias_moves;
    s_manual_steady ##0 $changed(laser_bias_current_o);
  endsequence

  a_aux_follows_code: assert property (aux_wr
    |-> ##2 aux_analog_out_one_o == $past(bus_wdata_i, 2))
    else $error("aux output did not follow its code write");
  a_aux_holds_value: assert property ($changed(aux_analog_out_one_o) |-> $past(aux_wr, 2))
    else $error("aux output moved without a code write");
  a_locked_reads_zero: assert property (cfg_rd && bus_addr_i[7] && !level_two_password_i
    |=> bus_rdata_o == 8'h00)
    else $error("config read without password returned data");
  a_reserved_reads_zero: assert property (cfg_rd && rsv |=> bus_rdata_o == 8'h00)
    else $error("reserved or empty offset returned data");
  a_table_rsv_zero: assert property (cfg_rd && bus_addr_i == OFF_VTABLE_SEL
    |=> bus_rdata_o[7:2] == 6'h00)
    else $error("table control reserved bits not zero");
  a_live_high_byte: assert property (cfg_rd && level_two_password_i
    && bus_addr_i == OFF_LIVE_HIGH |=> bus_rdata_o == {2'b00, $past(laser_bias_current_o[13:8])})
    else $error("live code high byte wrong");
  a_live_low_byte: assert property (cfg_rd && level_two_password_i
    && bus_addr_i == OFF_LIVE_LOW |=> bus_rdata_o == $past(laser_bias_current_o[7:0]))
    else $error("live code low byte wrong");
  a_manual_needs_strobe: assert property (s_bias_moves |-> $past(strb_wr, 2))
    else $error("manual bias code changed without a strobe write");
endmodule : abm_regs_chk

`default_nettype wire

// file: tb/tb_top.sv
// tb_top: directed register sequences against abm_regs through abm_host
// assumes 100 MHz clock, synchronous active-high reset held 12 cycles
`default_nettype none

module tb_top;
  import abm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] NV = 8'h0A;
  localparam logic [7:0] RSV [7] = '{8'hC1, 8'hC2, 8'hC3, 8'hC5, 8'hC6, 8'hC8, 8'hF7};
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic pw = 1'b1;
  logic los = 1'b0;
  logic auto = 1'b0;
  logic done = 1'b0;
  logic [4:0] idx = 5'h13;
  logic [13:0] acode = 14'h0000;
  logic [7:0] lim = 8'hFF;
  logic [7:0] page, addr, wdata, rdata, aux, vout, rdv;
  logic wr, rd, p0, p1, p2, p3;
  logic [13:0] bias;
  int fail_count = 0;
  int tests_run = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  abm_host host (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .page_o(page), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  abm_regs dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .bus_page_i(page), .bus_addr_i(addr),
    .bus_wr_i(wr), .bus_rd_i(rd), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
    .level_two_password_i(pw), .nv_powerup_ctl_i(NV), .loss_of_signal_input_i(los),
    .bias_auto_enable_i(auto), .auto_bias_code_i(acode), .max_bias_limit_i(lim),
    .monitor_four_done_i(done), .monitor_input_four_index_i(idx), .general_out_pin_0_o(p0),
    .general_out_pin_1_o(p1), .general_out_pin_2_o(p2), .general_out_pin_3_o(p3),
    .aux_analog_out_one_o(aux), .voltage_indexed_output_o(vout), .laser_bias_current_o(bias));

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rchk(input string nm, input logic [7:0] ad, input logic [7:0] exp);
    host.rd(PAGE_CFG, ad, rdv);
    chk(nm, {8'h00, rdv}, {8'h00, exp});
  endtask : rchk
  task automatic strobe_chk(input string nm, input logic [13:0] exp);
    host.wr(PAGE_CFG, OFF_MAN_STROBE, 8'h01);
    repeat (2) @(negedge sys_clk_i);
    chk(nm, {2'b00, bias}, {2'b00, exp});
  endtask : strobe_chk
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // whole sequence is well under 2000 cycles; this leaves ample margin
  initial
  begin
    #300us;
    fail_count++;
    give_verdict();
  end

  initial
  begin
    repeat (12) @(negedge sys_clk_i);
    reset_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    chk("pins", {12'h000, p3, p2, p1, p0}, {12'h000, NV[3:0]});
    rchk("pwrup", OFF_POWERUP_CTL, NV);
    pw = 1'b0;
    host.wr(PAGE_CFG, OFF_AUX_CODE, 8'h5A);
    rchk("aux_locked", OFF_AUX_CODE, 8'h00);
    pw = 1'b1;
    rchk("aux_kept", OFF_AUX_CODE, RST_BYTE);
    host.wr(PAGE_CFG, OFF_AUX_CODE, 8'hA5);
    repeat (2) @(negedge sys_clk_i);
    chk("aux_out", {8'h00, aux}, 16'h00A5);
    // i: bit0 input level, bit1 passthrough, bit2 invert, bit3 out-state
    for (int i = 0; i < 16; i++)
    begin
      los = i[0];
      host.wr(8'h00, OFF_OUT_STATE, {7'h00, i[3]});
      host.wr(PAGE_CFG, OFF_POWERUP_CTL, {2'b00, i[2], i[1], 4'h0});
      repeat (4) @(negedge sys_clk_i);
      chk("pin0", {15'h0000, p0}, {15'h0000, i[1] ? i[0] ^ i[2] : i[3]});
    end
    host.rd(8'h00, OFF_OUT_STATE, rdv);
    chk("out_state", {8'h00, rdv}, 16'h0001);
    for (int a = 0; a < VLUT_DEPTH; a++)
      host.wr(PAGE_VLUT, OFF_VLUT_FIRST + 8'(a), 8'h40 + 8'(a));
    for (int m = 0; m < 4; m++)
    begin
      host.wr(PAGE_CFG, OFF_VTABLE_SEL, 8'hFC | 8'(m));
      rchk("tbl_sel", OFF_VTABLE_SEL, 8'(m));
      done = 1'b1;
      @(negedge sys_clk_i);
      done = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      chk("vout", {8'h00, vout}, m[1] ? {11'h002, m[0], 4'h9} : 16'h0053);
    end
    // table change without a conversion must not reach the held output
    host.wr(PAGE_VLUT, 8'h99, 8'h00);
    chk("vout_held", {8'h00, vout}, 16'h0059);
    host.rd(PAGE_VLUT, 8'h99, rdv);
    chk("vlut_rd", {8'h00, rdv}, 16'h0000);
    foreach (RSV[k])
    begin
      host.wr(PAGE_CFG, RSV[k], 8'hFF);
      rchk("reserved", RSV[k], 8'h00);
    end
    auto = 1'b1;
    acode = 14'h1234;
    repeat (3) @(negedge sys_clk_i);
    chk("auto", {2'b00, bias}, 16'h1234);
    host.wr(PAGE_CFG, OFF_LIVE_LOW, 8'h00);
    rchk("live_hi", OFF_LIVE_HIGH, 8'h12);
    rchk("live_lo", OFF_LIVE_LOW, 8'h34);
    lim = 8'h10;
    repeat (3) @(negedge sys_clk_i);
    chk("clamp", {2'b00, bias}, 16'h043F);
    auto = 1'b0;
    host.wr(PAGE_CFG, OFF_MAN_HIGH, 8'hFF);
    host.wr(PAGE_CFG, OFF_MAN_LOW, 8'hA5);
    strobe_chk("man_load", 14'h3FA5);
    rchk("live_top", OFF_LIVE_HIGH, 8'h3F);
    host.wr(PAGE_CFG, OFF_MAN_LOW, 8'h00);
    strobe_chk("man_held", 14'h3FA5);
    host.wr(PAGE_CFG, OFF_MAN_STROBE, 8'h00);
    strobe_chk("man_reload", 14'h3F00);
    host.wr(PAGE_CFG, OFF_MAN_STROBE, 8'h00);
    auto = 1'b1;
    host.wr(PAGE_CFG, OFF_MAN_LOW, 8'h77);
    auto = 1'b0;
    strobe_chk("auto_drop", 14'h3F00);
    give_verdict();
  end
endmodule : tb_top

bind abm_regs abm_regs_chk chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .bus_page_i(bus_page_i), .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
  .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
  .level_two_password_i(level_two_password_i), .bias_auto_enable_i(bias_auto_enable_i),
  .aux_analog_out_one_o(aux_analog_out_one_o), .laser_bias_current_o(laser_bias_current_o));

`default_nettype wire

// file: verilog/abm_regs.sv
// abm_regs: aux pin, aux analog code, voltage table select and manual bias bank
// assumes a serial front end on sys_clk_i presents one-cycle byte accesses
// What this block does
// - pin-0 source select picks out-state bit 0 or buffered loss-of-signal input.
// - invert bit flips the passed-through input; ignored when passthrough is off.
// - at power-on the four stored power-up bits load the four out-state bits.
// - aux analog code register at C4h sets the first aux analog output.
// - split bit chooses one 32-byte table or two 16-byte tables.
// - with split tables, half bit picks 80h-8Fh or 90h-9Fh.
// - bits 7 down to 2 of the table control register stay zero.
// - manual bias bytes F8h/F9h accept writes only while automatic bias is off.
// - in manual mode, setting strobe bit 0 moves the staged code to the DAC.
// - FBh/FCh read the live bias code, top two bits zero, writes ignored.
// - C8h-F7h and reserved C1h-C3h, C5h-C6h have no storage or function.
// - reads and writes of this page need level-two password access.
// - monitor-4 reading indexes the table; result held until next conversion.
// - maximum-bias limit FFh leaves automatic control unclamped; 00h-FEh clamp automatic control.
`default_nettype none

module abm_regs
  import abm_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] bus_page_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_wdata_i,
  output logic [7:0] bus_rdata_o,
  input wire logic level_two_password_i,
  input wire logic [7:0] nv_powerup_ctl_i,
  input wire logic loss_of_signal_input_i,
  input wire logic bias_auto_enable_i,
  input wire logic [BIAS_W-1:0] auto_bias_code_i,
  input wire logic [7:0] max_bias_limit_i,
  input wire logic monitor_four_done_i,
  input wire logic [VLUT_IDX_W-1:0] monitor_input_four_index_i,
  output logic general_out_pin_0_o,
  output logic general_out_pin_1_o,
  output logic general_out_pin_2_o,
  output logic general_out_pin_3_o,
  output logic [7:0] aux_analog_out_one_o,
  output logic [7:0] voltage_indexed_output_o,
  output logic [BIAS_W-1:0] laser_bias_current_o
);

  logic [5:0] powerup_ctl;
  logic [3:0] out_state;
  logic [7:0] aux_code;
  logic [1:0] vtable_sel;
  logic [7:0] man_high;
  logic [7:0] man_low;
  logic man_strobe;
  logic man_strobe_seen;
  logic power_on_load;
  logic los_sync;
  logic [7:0] next_rdata;
  logic [BIAS_W-1:0] next_bias;
  logic [7:0] vlut_rd_data;

  // decode
  wire cfg_page = (bus_page_i == PAGE_CFG) && bus_addr_i[7];
  wire vlut_page = (bus_page_i == PAGE_VLUT) && (bus_addr_i >= OFF_VLUT_FIRST)
    && (bus_addr_i <= OFF_VLUT_LAST);
  wire lower_mem = !bus_addr_i[7];
  wire granted = level_two_password_i;
  wire cfg_wr = bus_wr_i && cfg_page && granted;
  wire wr_powerup = cfg_wr && (bus_addr_i == OFF_POWERUP_CTL);
  wire wr_aux = cfg_wr && (bus_addr_i == OFF_AUX_CODE);
  wire wr_vsel = cfg_wr && (bus_addr_i == OFF_VTABLE_SEL);
  wire manual_mode = !bias_auto_enable_i;
  wire wr_man_high = cfg_wr && (bus_addr_i == OFF_MAN_HIGH) && manual_mode;
  wire wr_man_low = cfg_wr && (bus_addr_i == OFF_MAN_LOW) && manual_mode;
  wire wr_strobe = cfg_wr && (bus_addr_i == OFF_MAN_STROBE) && manual_mode;
  wire wr_out_state = bus_wr_i && lower_mem && (bus_addr_i == OFF_OUT_STATE);
  wire wr_vlut = bus_wr_i && vlut_page && granted;
  wire [BIAS_W-1:0] staged_code = {man_high[BIAS_W-9:0], man_low};
  // a strobe held at 1 must not keep reloading, so only the rising edge counts
  wire strobe_rise = man_strobe && !man_strobe_seen;
  wire limit_is_manual = (max_bias_limit_i == MAX_LIMIT_MANUAL);
  wire auto_over = auto_bias_code_i[BIAS_W-1:BIAS_W-8] > max_bias_limit_i;
  wire [BIAS_W-1:0] clamped_auto = {max_bias_limit_i, CLAMP_LOW_FILL};
  wire pass_sel = powerup_ctl[POS_PIN0_SOURCE];
  wire pass_inv = powerup_ctl[POS_PASS_INVERT];
  wire next_pin0 = pass_sel ? (los_sync ^ pass_inv) : out_state[0];

  abm_sync #(
    .WIDTH(1)
  ) u_los_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .async_i(loss_of_signal_input_i),
    .sync_o(los_sync)
  );

  abm_vlut #(
    .DEPTH(VLUT_DEPTH),
    .IDX_W(VLUT_IDX_W)
  ) u_vlut (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .wr_en_i(wr_vlut),
    .wr_idx_i(bus_addr_i[VLUT_IDX_W-1:0]),
    .wr_data_i(bus_wdata_i),
    .rd_idx_i(bus_addr_i[VLUT_IDX_W-1:0]),
    .rd_data_o(vlut_rd_data),
    .conv_done_i(monitor_four_done_i),
    .conv_index_i(monitor_input_four_index_i),
    .split_i(vtable_sel[POS_TABLE_SPLIT]),
    .half_i(vtable_sel[POS_TABLE_HALF]),
    .held_o(voltage_indexed_output_o)
  );

  // bias DAC source
  always_comb
  begin
    next_bias = laser_bias_current_o;
    if (!manual_mode && !limit_is_manual)
    begin
      next_bias = auto_over ? clamped_auto : auto_bias_code_i;
    end
    else if (!manual_mode)
    begin
      next_bias = auto_bias_code_i;
    end
    else if (strobe_rise)
    begin
      next_bias = staged_code;
    end
  end

  // read mux; anything unmapped, or in the config or table page while not granted, reads zero
  always_comb
  begin
    next_rdata = RST_BYTE;
    if (cfg_page && granted)
    begin
      unique case (bus_addr_i)
        OFF_POWERUP_CTL: next_rdata = {2'b00, powerup_ctl};
        OFF_AUX_CODE: next_rdata = aux_code;
        OFF_VTABLE_SEL: next_rdata = {6'b000000, vtable_sel};
        OFF_MAN_HIGH: next_rdata = man_high;
        OFF_MAN_LOW: next_rdata = man_low;
        OFF_MAN_STROBE: next_rdata = {7'b0000000, man_strobe};
        OFF_LIVE_HIGH: next_rdata = {2'b00, laser_bias_current_o[BIAS_W-1:8]};
        OFF_LIVE_LOW: next_rdata = laser_bias_current_o[7:0];
        default: next_rdata = RST_BYTE;
      endcase
    end
    else if (vlut_page && granted)
    begin
      next_rdata = vlut_rd_data;
    end
    else if (lower_mem && (bus_addr_i == OFF_OUT_STATE))
    begin
      next_rdata = {4'h0, out_state};
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      bus_rdata_o <= RST_BYTE;
    end
    else if (bus_rd_i)
    begin
      bus_rdata_o <= next_rdata;
    end
  end

  // restore the stored byte once, on the first edge after reset release
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      power_on_load <= 1'b1;
    end
    else
    begin
      power_on_load <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      powerup_ctl <= RST_BYTE[5:0];
    end
    else if (power_on_load)
    begin
      powerup_ctl <= nv_powerup_ctl_i[5:0];
    end
    else if (wr_powerup)
    begin
      powerup_ctl <= bus_wdata_i[5:0];
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      out_state <= RST_OUT_STATE;
    end
    else if (power_on_load)
    begin
      out_state <= nv_powerup_ctl_i[3:0];
    end
    else if (wr_out_state)
    begin
      out_state <= bus_wdata_i[3:0];
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      aux_code <= RST_BYTE;
      vtable_sel <= RST_BYTE[1:0];
    end
    else
    begin
      if (wr_aux)
      begin
        aux_code <= bus_wdata_i;
      end
      if (wr_vsel)
      begin
        vtable_sel <= bus_wdata_i[1:0];
      end
    end
  end

  // staging bytes; live bytes FBh/FCh have no write path at all
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      man_high <= RST_BYTE;
      man_low <= RST_BYTE;
    end
    else
    begin
      if (wr_man_high)
      begin
        man_high <= {2'b00, bus_wdata_i[5:0]};
      end
      if (wr_man_low)
      begin
        man_low <= bus_wdata_i;
      end
    end
  end

  // host is expected to write code, strobe 1, strobe 0 as separate accesses
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      man_strobe <= 1'b0;
      man_strobe_seen <= 1'b0;
    end
    else
    begin
      if (wr_strobe)
      begin
        man_strobe <= bus_wdata_i[POS_STROBE];
      end
      man_strobe_seen <= man_strobe;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      laser_bias_current_o <= RST_BIAS_CODE;
    end
    else
    begin
      laser_bias_current_o <= next_bias;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      general_out_pin_0_o <= 1'b0;
      general_out_pin_1_o <= 1'b0;
      general_out_pin_2_o <= 1'b0;
      general_out_pin_3_o <= 1'b0;
      aux_analog_out_one_o <= RST_BYTE;
    end
    else
    begin
      general_out_pin_0_o <= next_pin0;
      general_out_pin_1_o <= out_state[1];
      general_out_pin_2_o <= out_state[2];
      general_out_pin_3_o <= out_state[3];
      aux_analog_out_one_o <= aux_code;
    end
  end

endmodule : abm_regs

`default_nettype wire

// file: verilog/abm_sync.sv
// abm_sync: two-flop synchroniser for a level from a pin
// assumes the level is slow against sys_clk_i; no pulse is guaranteed to pass
`default_nettype none

module abm_sync
  import abm_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      meta <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule : abm_sync

`default_nettype wire

// file: verilog/abm_vlut.sv
// abm_vlut: voltage-indexed lookup table and its held output value
// assumes conversion strobes and index come from logic on sys_clk_i
`default_nettype none

module abm_vlut
  import abm_pkg::*;
#(
  parameter int DEPTH = VLUT_DEPTH,
  parameter int IDX_W = VLUT_IDX_W
)
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic wr_en_i,
  input wire logic [IDX_W-1:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [IDX_W-1:0] rd_idx_i,
  output logic [7:0] rd_data_o,
  input wire logic conv_done_i,
  input wire logic [IDX_W-1:0] conv_index_i,
  input wire logic split_i,
  input wire logic half_i,
  output logic [7:0] held_o
);

  logic [7:0] table_mem [DEPTH];
  logic [IDX_W-1:0] lookup_idx;

  // split halves use the top index bits so each half spans the full input range
  assign lookup_idx = split_i ? {half_i, conv_index_i[IDX_W-1:1]} : conv_index_i;
  assign rd_data_o = table_mem[rd_idx_i];

  always_ff @(posedge sys_clk_i)
  begin
    if (wr_en_i)
    begin
      table_mem[wr_idx_i] <= wr_data_i;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      held_o <= RST_BYTE;
    end
    else if (conv_done_i)
    begin
      held_o <= table_mem[lookup_idx];
    end
  end

endmodule : abm_vlut

`default_nettype wire
